// File: verilog/iomsg_glue.sv
`timescale 1ns/10ps
// Function
// - one-of-eight decode splits port space into eight four-port blocks
// - blocks 80h parallel, 84h timer, 88h segment, 8ch digit, 90h keyboard
// - peripherals use the two low address bits to pick their register
// - 80h/81h data a/b, 82h/83h control a/b; 84h-87h timer channels 0-3
// - spare port selects 94h-9fh brought out for custom circuitry
// - memory selects for regions 3, 5, 6, 7 brought out
// - ram region holds 1k standard plus 1k expansion
// - timer channel 2 pulses at first user instruction after step request
// - channel 2 zero-count pulse gated onto processor nmi
// - single step works from ram or rom via hardware nmi path
// - interrupt priority settled by an enable-in/enable-out daisy chain
// - timer heads the chain, parallel i/o follows
// - last peripheral chain output is available externally
// - lowest 16k fully decoded into eight 2k regions
// - monitor 0000h, user prom 0800h, program prom 1000h, ram 2000h
// - restart switch readable on keyboard port 90h during reset sequence
module iomsg_glue (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       nrst,
   // processor bus
   input  wire logic [15:0] addr,
   input  wire logic       mreq_n,
   input  wire logic       iorq_n,
   input  wire logic       m1_n,
   input  wire logic       rd_n,
   output logic            nmi_n,
   // keyboard data into read path
   input  wire logic [6:0] key_data,
   input  wire logic       restart_switch,
   output logic      [7:0] key_port_data,
   output logic            key_port_oe,
   // single step
   input  wire logic       timer_ch2_zero_pulse,
   input  wire logic       step_enable,
   // interrupt daisy chain
   input  wire logic       priority_chain_in,
   input  wire logic       timer_chain_out,
   input  wire logic       parallel_chain_out,
   output logic            timer_chain_in,
   output logic            parallel_chain_in,
   output logic            priority_chain_out,
   // peripheral port selects
   output logic            parallel_sel_n,
   output logic            timer_sel_n,
   output logic            seg_latch_sel_n,
   output logic            digit_latch_sel_n,
   output logic            keyboard_sel_n,
   output logic            io_block_sel_5,
   output logic            io_block_sel_6,
   output logic            io_block_sel_7,
   output logic      [1:0] periph_reg_addr,
   output logic            parallel_ctrl,
   output logic            parallel_port_b,
   // memory selects
   output logic            monitor_select,
   output logic            user_prom_select,
   output logic            program_prom_select,
   output logic            ram_std_select,
   output logic            ram_exp_select,
   output logic            mem_region_sel_3,
   output logic            mem_region_sel_5,
   output logic            mem_region_sel_6,
   output logic            mem_region_sel_7
);
   logic [7:0] port_n;
   logic [7:0] region_n;
   logic       io_cycle;
   logic       mem_cycle;
   // address fields feeding the decoders
   logic [2:0] port_blk;
   logic [2:0] mem_region;
   logic       ram_cycle;

   // acknowledge cycles carry iorq with m1 low and must not select a port
   assign io_cycle  = !iorq_n && m1_n &&
                      (addr[7:5] == iomsg_pkg::PORT_BASE_HI);
   assign mem_cycle = !mreq_n && (addr[15:14] == 2'h0);
   assign port_blk   = addr[iomsg_pkg::PORT_BLK_LSB +: iomsg_pkg::PORT_BLK_BITS];
   assign mem_region = addr[iomsg_pkg::MEM_REGION_LSB +: 3];

   // ram decode runs beside the region decoder so both ram selects leave flops
   assign ram_cycle = mem_cycle && (mem_region == iomsg_pkg::REG_RAM);

   // port blocks: a7..a5 fixed at 100, a4..a2 pick one of eight
   iomsg_decode8 u_port_dec (
      .clk   (clk),
      .nrst  (nrst),
      .enable(io_cycle),
      .sel   (port_blk),
      .out_n (port_n)
   );

   // memory regions: a15..a14 zero, a13..a11 pick one 2k region
   iomsg_decode8 u_mem_dec (
      .clk   (clk),
      .nrst  (nrst),
      .enable(mem_cycle),
      .sel   (mem_region),
      .out_n (region_n)
   );

   // block selects, one cycle behind the bus like the decoder outputs
   always_comb begin
      parallel_sel_n    = port_n[iomsg_pkg::BLK_PARALLEL];
      timer_sel_n       = port_n[iomsg_pkg::BLK_TIMER];
      seg_latch_sel_n   = port_n[iomsg_pkg::BLK_SEG_LATCH];
      digit_latch_sel_n = port_n[iomsg_pkg::BLK_DIGIT];
      keyboard_sel_n    = port_n[iomsg_pkg::BLK_KEYBOARD];
      io_block_sel_5    = port_n[iomsg_pkg::BLK_SPARE5];
      io_block_sel_6    = port_n[iomsg_pkg::BLK_SPARE6];
      io_block_sel_7    = port_n[iomsg_pkg::BLK_SPARE7];
      // memory selects; the ram region leaves through its own bank flops
      monitor_select      = region_n[iomsg_pkg::REG_MONITOR];
      user_prom_select    = region_n[iomsg_pkg::REG_USER_PROM];
      program_prom_select = region_n[iomsg_pkg::REG_PROG_PROM];
      mem_region_sel_3    = region_n[3];
      mem_region_sel_5    = region_n[5];
      mem_region_sel_6    = region_n[6];
      mem_region_sel_7    = region_n[7];
   end

   // register index within a block, registered with the selects
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         periph_reg_addr <= 2'h0;
      end else begin
         periph_reg_addr <= addr[1:0];
      end
   end

   // parallel i/o: a1 picks data or control, a0 picks side a or b
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         parallel_ctrl   <= 1'b0;
         parallel_port_b <= 1'b0;
      end else begin
         parallel_ctrl   <= addr[1];
         parallel_port_b <= addr[0];
      end
   end

   // ram region split into standard and expansion 1k banks on a10; both
   // selects come from flops, so no decode glitch reaches the ram chips
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ram_std_select <= 1'b1;
      end else begin
         ram_std_select <= !(ram_cycle && !addr[iomsg_pkg::RAM_BANK_BIT]);
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ram_exp_select <= 1'b1;
      end else begin
         ram_exp_select <= !(ram_cycle && addr[iomsg_pkg::RAM_BANK_BIT]);
      end
   end

   // single step: the timer pulse reaches nmi only while stepping is armed,
   // so free-running channel 2 use (prom programming) never traps;
   // a pulse that spans no rising clock edge is not seen, and step_enable
   // must stay high until the timer pulse has been taken
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         nmi_n <= 1'b1;
      end else begin
         nmi_n <= !(timer_ch2_zero_pulse && step_enable);
      end
   end

   // keyboard port read path carries the restart switch on the top bit
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         key_port_data <= 8'h00;
      end else begin
         key_port_data <= {restart_switch, key_data};
      end
   end

   // enable only on reads, so a write to the block never fights the bus
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         key_port_oe <= 1'b0;
      end else begin
         key_port_oe <= io_cycle && !rd_n &&
                        (port_blk == iomsg_pkg::BLK_KEYBOARD);
      end
   end

   // daisy chain: timer first, parallel i/o second, then out
   // each hop costs one cycle, so the chain needs three cycles to settle
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         timer_chain_in <= 1'b0;
      end else begin
         timer_chain_in <= priority_chain_in;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         parallel_chain_in <= 1'b0;
      end else begin
         parallel_chain_in <= timer_chain_out;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         priority_chain_out <= 1'b0;
      end else begin
         priority_chain_out <= parallel_chain_out;
      end
   end
endmodule // iomsg_glue

// File: verilog/iomsg_pkg.sv
package iomsg_pkg;
   // i/o port decode: a[7:5] must be 3'b100, a[4:2] picks the block
   localparam logic [2:0] PORT_BASE_HI   = 3'h4;
   localparam int         PORT_BLK_LSB   = 2;
   localparam int         PORT_BLK_BITS  = 3;
   localparam int         PORT_BLK_COUNT = 8;
   // port blocks
   localparam logic [2:0] BLK_PARALLEL   = 3'h0;
   localparam logic [2:0] BLK_TIMER      = 3'h1;
   localparam logic [2:0] BLK_SEG_LATCH  = 3'h2;
   localparam logic [2:0] BLK_DIGIT      = 3'h3;
   localparam logic [2:0] BLK_KEYBOARD   = 3'h4;
   localparam logic [2:0] BLK_SPARE5     = 3'h5;
   localparam logic [2:0] BLK_SPARE6     = 3'h6;
   localparam logic [2:0] BLK_SPARE7     = 3'h7;
   // memory decode: a[15:14] zero, a[13:11] picks a 2k region
   localparam int         MEM_REGION_LSB = 11;
   localparam int         MEM_REGION_CNT = 8;
   localparam logic [2:0] REG_MONITOR    = 3'h0;
   localparam logic [2:0] REG_USER_PROM  = 3'h1;
   localparam logic [2:0] REG_PROG_PROM  = 3'h2;
   localparam logic [2:0] REG_RAM        = 3'h4;
   // ram: 1k standard, second 1k is expansion (a[10])
   localparam int         RAM_BANK_BIT   = 10;
   // keyboard port bit that carries the restart switch
   localparam int         RESTART_BIT    = 7;
   // nmi vector as seen by the processor
   localparam logic [15:0] NMI_VECTOR    = 16'h0066;
   localparam logic [15:0] USER_RESTART  = 16'h0800;
endpackage

// File: verilog/iomsg_decode8.sv
`timescale 1ns/10ps
// one-of-eight decoder with active-low outputs, registered
module iomsg_decode8 (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       nrst,
   // decode request
   input  wire logic       enable,
   input  wire logic [2:0] sel,
   // selects, active low
   output logic      [7:0] out_n
);
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         out_n <= 8'hff;
      end else begin
         out_n <= enable ? ~(8'h01 << sel) : 8'hff;
      end
   end
endmodule // iomsg_decode8

// File: testbench/iomsg_periph_model.sv
`timescale 1ns/10ps
// far-side peripherals on the priority chain; a pending one blocks all below it
module iomsg_periph_model (
   // chain inputs and pending requests
   input  logic timer_chain_in,
   input  logic parallel_chain_in,
   input  logic timer_busy,
   input  logic parallel_busy,
   // chain outputs
   output logic timer_chain_out,
   output logic parallel_chain_out
);
   assign timer_chain_out    = timer_chain_in && !timer_busy;
   assign parallel_chain_out = parallel_chain_in && !parallel_busy;
endmodule // iomsg_periph_model

// File: testbench/iomsg_glue_assertions.sv
`timescale 1ns/10ps
module iomsg_glue_assertions (
   // clock and reset
   input logic        clk,
   input logic        nrst,
   // processor bus
   input logic [15:0] addr,
   input logic        mreq_n,
   input logic        iorq_n,
   input logic        m1_n,
   input logic        rd_n,
   input logic        nmi_n,
   // keyboard port
   input logic        restart_switch,
   input logic [7:0]  key_port_data,
   input logic        key_port_oe,
   // single step
   input logic        timer_ch2_zero_pulse,
   input logic        step_enable,
   // daisy chain
   input logic        priority_chain_in,
   input logic        timer_chain_in,
   // selects
   input logic [1:0]  periph_reg_addr,
   input logic        timer_sel_n,
   input logic        parallel_sel_n,
   input logic        keyboard_sel_n,
   input logic        io_block_sel_5,
   input logic        io_block_sel_7,
   input logic        user_prom_select,
   input logic        ram_std_select,
   input logic        ram_exp_select,
   input logic        mem_region_sel_3
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   wire io = !iorq_n && m1_n && addr[7:5] == 3'h4;
   a_timer_block: assert property (io && addr[4:2] == 3'h1 |=>
      !timer_sel_n && periph_reg_addr == $past(addr[1:0])) else $error("timer select");
   a_parallel_blk: assert property (io && addr[4:2] == 3'h0 |=>
      !parallel_sel_n && timer_sel_n) else $error("parallel select");
   a_spare_block: assert property (io && addr[4:2] == 3'h7 |=>
      !io_block_sel_7 && io_block_sel_5) else $error("spare select");
   a_ack_no_port: assert property (!iorq_n && !m1_n |=>
      parallel_sel_n && timer_sel_n && keyboard_sel_n) else $error("port on acknowledge");
   a_key_read: assert property (io && !rd_n && addr[4:2] == 3'h4 |=>
      key_port_oe && key_port_data[7] == $past(restart_switch)) else $error("key read");
   a_ram_bank: assert property (!mreq_n && addr[15:11] == 5'h04 |=>
      ram_exp_select != $past(addr[10]) && ram_std_select == $past(addr[10]))
      else $error("ram bank");
   a_mem_high: assert property (!mreq_n && addr[15:14] != 2'h0 |=>
      user_prom_select && ram_std_select && mem_region_sel_3) else $error("high memory");
   a_region_3: assert property (!mreq_n && addr[15:11] == 5'h03 |=>
      !mem_region_sel_3 && user_prom_select) else $error("region 3");
   a_step_nmi: assert property (nrst && timer_ch2_zero_pulse && step_enable |=>
      !nmi_n) else $error("nmi missing");
   a_no_step: assert property (nrst && !timer_ch2_zero_pulse |=> nmi_n)
      else $error("nmi spurious");
   a_chain_delay: assert property (nrst |=>
      timer_chain_in == $past(priority_chain_in)) else $error("chain delay");
endmodule // iomsg_glue_assertions
bind iomsg_glue iomsg_glue_assertions chk (.*);

// File: testbench/iomsg_glue_tb_top.sv
`timescale 1ns/10ps
module iomsg_glue_tb_top;
   logic clk = 0, nrst = 0, mreq_n = 1, iorq_n = 1, m1_n = 1, rd_n = 1, restart_switch = 1;
   logic [15:0] addr = 16'h0;
   logic [6:0] key_data = 7'h5a;
   logic timer_ch2_zero_pulse = 0, step_enable = 0, priority_chain_in = 1;
   logic timer_busy = 0, parallel_busy = 0, timer_chain_out, parallel_chain_out, nmi_n;
   logic key_port_oe, timer_chain_in, parallel_chain_in, priority_chain_out, parallel_sel_n;
   logic timer_sel_n, seg_latch_sel_n, digit_latch_sel_n, keyboard_sel_n, io_block_sel_5;
   logic io_block_sel_6, io_block_sel_7, parallel_ctrl, parallel_port_b, monitor_select;
   logic user_prom_select, program_prom_select, ram_std_select, ram_exp_select;
   logic mem_region_sel_3, mem_region_sel_5, mem_region_sel_6, mem_region_sel_7;
   logic [7:0] key_port_data;
   logic [1:0] periph_reg_addr;
   int n_fail = 0, comparisons = 0;
   iomsg_glue dut (.*);
   iomsg_periph_model model (.*);
   initial forever #12.5 clk = ~clk;
   task chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task test_done;
      $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // one bus cycle; outputs answer one cycle after the bus is driven
   task bus(input logic [15:0] a, input logic mq, input logic iq, input logic m1);
      @(posedge clk);
      addr <= a;
      mreq_n <= mq;
      iorq_n <= iq;
      m1_n <= m1;
      rd_n <= 1'b0;
      @(posedge clk);
      #1;
   endtask
   task t_ports;
      for (int b = 0; b < 8; b++) begin
         for (int lo = 0; lo < 4; lo += 3) begin
            bus({8'h00, 3'h4, b[2:0], lo[1:0]}, 1'b1, 1'b0, 1'b1);
            chk({io_block_sel_7, io_block_sel_6, io_block_sel_5, keyboard_sel_n,
                 digit_latch_sel_n, seg_latch_sel_n, timer_sel_n, parallel_sel_n},
                8'(~(8'h01 << b)));
            chk(periph_reg_addr, lo[1:0]);
            chk({parallel_ctrl, parallel_port_b}, lo[1:0]);
            chk(key_port_oe, b == 4);
            if (b == 4) chk(key_port_data, 8'hda);
         end
      end
      bus(16'h00a4, 1'b1, 1'b0, 1'b1);
      chk({timer_sel_n, parallel_sel_n, io_block_sel_5}, 3'h7);
      bus(16'h0084, 1'b1, 1'b0, 1'b0);
      chk({timer_sel_n, parallel_sel_n}, 2'h3);
   endtask
   task t_mem;
      for (int r = 0; r < 8; r++) begin
         bus({2'b00, r[2:0], 11'h400}, 1'b0, 1'b1, 1'b1);
         chk({mem_region_sel_7, mem_region_sel_6, mem_region_sel_5, ram_exp_select,
              mem_region_sel_3, program_prom_select, user_prom_select, monitor_select},
             8'(~(8'h01 << r)));
         chk(ram_std_select, 1'b1);
      end
      bus(16'h2000, 1'b0, 1'b1, 1'b1);
      chk({ram_std_select, ram_exp_select}, 2'b01);
      bus(16'h4800, 1'b0, 1'b1, 1'b1);
      chk({user_prom_select, ram_std_select, ram_exp_select}, 3'h7);
      bus(16'h0800, 1'b1, 1'b1, 1'b1);
      chk(user_prom_select, 1'b1);
   endtask
   // switch low on the key port; restart and nmi targets land in their regions
   task t_restart;
      @(posedge clk);
      restart_switch <= 1'b0;
      bus(16'h0090, 1'b1, 1'b0, 1'b1);
      chk(key_port_data, 8'h5a);
      chk(key_port_data[iomsg_pkg::RESTART_BIT], 1'b0);
      bus(iomsg_pkg::USER_RESTART, 1'b0, 1'b1, 1'b0);
      chk({user_prom_select, monitor_select}, 2'b01);
      bus(iomsg_pkg::NMI_VECTOR, 1'b0, 1'b1, 1'b0);
      chk({monitor_select, user_prom_select}, 2'b01);
      @(posedge clk);
      restart_switch <= 1'b1;
   endtask
   // mid-run reset over a live keyboard read: every output back to idle
   task t_reset;
      @(posedge clk);
      addr <= 16'h0093;
      mreq_n <= 1'b1;
      iorq_n <= 1'b0;
      m1_n <= 1'b1;
      nrst <= 1'b0;
      @(posedge clk);
      #1;
      chk({nmi_n, key_port_oe, key_port_data, timer_chain_in, parallel_chain_in,
           priority_chain_out}, 13'h1000);
      chk({parallel_sel_n, timer_sel_n, seg_latch_sel_n, digit_latch_sel_n, keyboard_sel_n,
           io_block_sel_5, io_block_sel_6, io_block_sel_7}, 8'hff);
      chk({monitor_select, user_prom_select, program_prom_select, ram_std_select,
           ram_exp_select, mem_region_sel_3, mem_region_sel_5, mem_region_sel_6,
           mem_region_sel_7}, 9'h1ff);
      chk({periph_reg_addr, parallel_ctrl, parallel_port_b}, 4'h0);
      @(posedge clk);
      iorq_n <= 1'b1;
      nrst <= 1'b1;
      @(posedge clk);
      #1;
      chk(timer_chain_in, 1'b1);
   endtask
   task t_nmi(input logic en);
      @(posedge clk);
      step_enable <= en;
      timer_ch2_zero_pulse <= 1'b1;
      @(posedge clk);
      timer_ch2_zero_pulse <= 1'b0;
      #1;
      chk(nmi_n, !en);
      @(posedge clk);
      #1;
      chk(nmi_n, 1'b1);
   endtask
   // chain outputs settle three register stages after a change
   task t_chain(input logic pin, input logic tb, input logic pb, input logic [2:0] exp);
      @(posedge clk);
      priority_chain_in <= pin;
      timer_busy <= tb;
      parallel_busy <= pb;
      repeat (3) @(posedge clk);
      #1;
      chk({timer_chain_in, parallel_chain_in, priority_chain_out}, exp);
   endtask
   initial begin
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      t_ports;
      t_mem;
      t_restart;
      t_reset;
      t_nmi(1'b1);
      t_nmi(1'b0);
      t_chain(1'b1, 1'b0, 1'b0, 3'h7);
      t_chain(1'b1, 1'b1, 1'b0, 3'h4);
      t_chain(1'b1, 1'b0, 1'b1, 3'h6);
      t_chain(1'b0, 1'b0, 1'b0, 3'h0);
      test_done;
   end
endmodule // iomsg_glue_tb_top
